// [rtl/uvp_defines.svh]
`ifndef UVP_DEFINES_SVH
`define UVP_DEFINES_SVH

`define UVP_CLOCK_MHZ          250
`define UVP_PULSE_US           100
`define UVP_PULSE_CYC          (`UVP_PULSE_US * `UVP_CLOCK_MHZ)
`define UVP_SETUP_US           1
`define UVP_SETUP_CYC          (`UVP_SETUP_US * `UVP_CLOCK_MHZ)
`define UVP_HOLD_US            1
`define UVP_HOLD_CYC           (`UVP_HOLD_US * `UVP_CLOCK_MHZ)
`define UVP_VERIFY_VALID_NS    250
`define UVP_VERIFY_VALID_CYC   ((`UVP_VERIFY_VALID_NS * `UVP_CLOCK_MHZ + 999) / 1000)
`define UVP_ACCESS_NS          200
`define UVP_ACCESS_CYC         ((`UVP_ACCESS_NS * `UVP_CLOCK_MHZ + 999) / 1000)
`define UVP_FLOAT_NS           60
`define UVP_FLOAT_CYC          ((`UVP_FLOAT_NS * `UVP_CLOCK_MHZ + 999) / 1000)
`define UVP_MAX_PULSES         25
`define UVP_SYNC_CYC           4
`define UVP_ADDR_W             16
`define UVP_DATA_W             8
`define UVP_ID_LINE            9
`define UVP_ID_SEL_LINE        0

`endif

// [rtl/uvp_pkg.sv]
package uvp_pkg;
    typedef enum logic [3:0] {
        UVP_IDLE    = 4'b0000,
        UVP_SETUP   = 4'b0001,
        UVP_ACCESS  = 4'b0010,
        UVP_PROG_SU = 4'b0011,
        UVP_PULSE   = 4'b0100,
        UVP_PHOLD   = 4'b0101,
        UVP_VFY     = 4'b0110,
        UVP_CHECK   = 4'b0111,
        UVP_RECOVER = 4'b1000,
        UVP_DONE    = 4'b1001
    } uvp_state_e;

    typedef enum logic [1:0] {
        UVP_OP_READ  = 2'b00,
        UVP_OP_PROG  = 2'b01,
        UVP_OP_IDENT = 2'b10
    } uvp_op_e;
endpackage

// [rtl/uvp_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module uvp_sync
    import uvp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } uvp_sync_s;

    uvp_sync_s st;
    uvp_sync_s next_st;

    // Level moves only when second and third stages agree
    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.level[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;
endmodule
`default_nettype wire

// [rtl/uvp_prog_ctrl.sv]
// Summary of operation
// - Raise program supply and main supply for program modes; normal levels otherwise.
// - Strobe acts as device select; gate acts as common read line.
// - Drive the full byte and address steadily while programming.
// - Pulse the strobe low once address and data are stable.
// - Repeat fixed pulses with verify after each, at most 25.
// - Never hold strobe low statically; only discrete timed pulses.
// - Strobe held high on unselected devices inhibits programming.
// - Verify with gate and strobe low, sample after data valid delay.
// - Identification: high voltage on line nine, line zero picks byte.
// - Hold other address lines and controls low during identification.
`timescale 1ns/10ps
`default_nettype none
`include "uvp_defines.svh"
module uvp_prog_ctrl
    import uvp_pkg::*;
#(
    parameter int ADDR_W     = `UVP_ADDR_W,
    parameter int DATA_W     = `UVP_DATA_W,
    parameter int PULSE_CYC  = `UVP_PULSE_CYC,
    parameter int MAX_PULSES = `UVP_MAX_PULSES
) (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [1:0]        req_op,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_data,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    output logic                   rsp_fail,
    output logic [4:0]             rsp_pulses,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_id_high_volt,
    output logic [DATA_W-1:0]      mem_data_out,
    output logic                   mem_data_oe_n,
    input  wire logic [DATA_W-1:0] mem_data_in,
    output logic                   select_program_strobe_n,
    output logic                   output_gate_n,
    output logic                   program_supply_high,
    output logic                   main_supply_high
);
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] SETUP_C  = CNT_W'(`UVP_SETUP_CYC);
    localparam logic [CNT_W-1:0] HOLD_C   = CNT_W'(`UVP_HOLD_CYC);
    // Three sync stages plus the level flop sit between pin and sampler
    localparam logic [CNT_W-1:0] VALID_C  = CNT_W'(`UVP_VERIFY_VALID_CYC + `UVP_SYNC_CYC);
    localparam logic [CNT_W-1:0] ACCESS_C = CNT_W'(`UVP_ACCESS_CYC + `UVP_SYNC_CYC);
    localparam logic [CNT_W-1:0] FLOAT_C  = CNT_W'(`UVP_FLOAT_CYC);
    localparam logic [CNT_W-1:0] PULSE_C  = CNT_W'(PULSE_CYC);
    localparam logic [4:0]       MAXP_C   = 5'(MAX_PULSES);

    typedef struct packed {
        logic              rst_a;
        logic              rst_b;
        uvp_state_e        state;
        uvp_op_e           op;
        logic [CNT_W-1:0]  cnt;
        logic [4:0]        pulses;
        logic [ADDR_W-1:0] addr;
        logic              id_hv;
        logic [DATA_W-1:0] dout;
        logic              doe_n;
        logic              strobe_n;
        logic              gate_n;
        logic              vpp;
        logic              vcc;
        logic              rsp_valid;
        logic [DATA_W-1:0] rsp_data;
        logic              rsp_fail;
    } uvp_ctrl_s;

    uvp_ctrl_s         st;
    uvp_ctrl_s         next_st;
    logic              rst_sync_n;
    logic [DATA_W-1:0] data_seen;

    // Data pins come from another chip, so synchronise
    uvp_sync #(.WIDTH(DATA_W)) uvp_sync_inst (
        .clock   (clock),
        .reset_n (rst_sync_n),
        .pin     (mem_data_in),
        .level   (data_seen)
    );

    assign rst_sync_n = st.rst_b;

    always_comb begin
        next_st = st;
        next_st.rst_a = 1'b1;
        next_st.rst_b = st.rst_a;
        next_st.rsp_valid = 1'b0;
        if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
        end
        unique case (st.state)
            UVP_IDLE: begin
                // No request taken until the reset copy is released
                if (req_valid && st.rst_b) begin
                    next_st.op = uvp_op_e'(req_op);
                    next_st.addr = req_addr;
                    next_st.pulses = '0;
                    next_st.cnt = SETUP_C;
                    next_st.state = UVP_SETUP;
                    if (uvp_op_e'(req_op) == UVP_OP_PROG) begin
                        next_st.vpp = 1'b1;
                        next_st.vcc = 1'b1;
                        next_st.dout = req_data;
                        next_st.doe_n = 1'b0;
                    end else if (uvp_op_e'(req_op) == UVP_OP_IDENT) begin
                        next_st.id_hv = 1'b1;
                        next_st.addr = '0;
                        next_st.addr[`UVP_ID_SEL_LINE] = req_addr[`UVP_ID_SEL_LINE];
                    end
                end
            end
            UVP_SETUP: begin
                if (st.cnt == '0) begin
                    if (st.op == UVP_OP_PROG) begin
                        next_st.strobe_n = 1'b0;
                        next_st.cnt = PULSE_C;
                        next_st.pulses = st.pulses + 5'd1;
                        next_st.state = UVP_PULSE;
                    end else begin
                        next_st.strobe_n = 1'b0;
                        next_st.gate_n = 1'b0;
                        next_st.cnt = ACCESS_C;
                        next_st.state = UVP_ACCESS;
                    end
                end
            end
            UVP_ACCESS: begin
                if (st.cnt == '0) begin
                    next_st.rsp_data = data_seen;
                    next_st.rsp_fail = 1'b0;
                    next_st.strobe_n = 1'b1;
                    next_st.gate_n = 1'b1;
                    next_st.id_hv = 1'b0;
                    next_st.cnt = FLOAT_C;
                    next_st.state = UVP_RECOVER;
                end
            end
            UVP_PULSE: begin
                if (st.cnt == '0) begin
                    next_st.strobe_n = 1'b1;
                    next_st.cnt = HOLD_C;
                    next_st.state = UVP_PHOLD;
                end
            end
            UVP_PHOLD: begin
                if (st.cnt == '0) begin
                    // Program supply back to logic level for verify
                    next_st.vpp = 1'b0;
                    next_st.doe_n = 1'b1;
                    next_st.cnt = SETUP_C;
                    next_st.state = UVP_PROG_SU;
                end
            end
            UVP_PROG_SU: begin
                if (st.cnt == '0) begin
                    next_st.gate_n = 1'b0;
                    next_st.strobe_n = 1'b0;
                    next_st.cnt = VALID_C;
                    next_st.state = UVP_VFY;
                end
            end
            UVP_VFY: begin
                if (st.cnt == '0) begin
                    next_st.rsp_data = data_seen;
                    next_st.gate_n = 1'b1;
                    next_st.strobe_n = 1'b1;
                    next_st.state = UVP_CHECK;
                end
            end
            UVP_CHECK: begin
                if (st.rsp_data == st.dout) begin
                    next_st.rsp_fail = 1'b0;
                    next_st.vcc = 1'b0;
                    next_st.cnt = FLOAT_C;
                    next_st.state = UVP_RECOVER;
                end else if (st.pulses >= MAXP_C) begin
                    next_st.rsp_fail = 1'b1;
                    next_st.vcc = 1'b0;
                    next_st.cnt = FLOAT_C;
                    next_st.state = UVP_RECOVER;
                end else begin
                    next_st.vpp = 1'b1;
                    next_st.doe_n = 1'b0;
                    next_st.cnt = SETUP_C;
                    next_st.state = UVP_SETUP;
                end
            end
            UVP_RECOVER: begin
                if (st.cnt == '0) begin
                    next_st.state = UVP_DONE;
                end
            end
            UVP_DONE: begin
                next_st.rsp_valid = 1'b1;
                next_st.state = UVP_IDLE;
            end
            default: begin
                next_st.state = UVP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{rst_a: 1'b0, rst_b: 1'b0, state: UVP_IDLE, op: UVP_OP_READ, cnt: '0, pulses: '0,
                    addr: '0, id_hv: 1'b0, dout: '0, doe_n: 1'b1, strobe_n: 1'b1, gate_n: 1'b1,
                    vpp: 1'b0, vcc: 1'b0, rsp_valid: 1'b0, rsp_data: '0, rsp_fail: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign req_ready               = (st.state == UVP_IDLE) && st.rst_b;
    assign rsp_valid               = st.rsp_valid;
    assign rsp_data                = st.rsp_data;
    assign rsp_fail                = st.rsp_fail;
    assign rsp_pulses              = st.pulses;
    assign mem_addr                = st.addr;
    assign mem_id_high_volt        = st.id_hv;
    assign mem_data_out            = st.dout;
    assign mem_data_oe_n           = st.doe_n;
    assign select_program_strobe_n = st.strobe_n;
    assign output_gate_n           = st.gate_n;
    assign program_supply_high     = st.vpp;
    assign main_supply_high        = st.vcc;

    // Strobe high except in pulse, read access and verify keeps others inhibited
    sequence s_pulse_start;
        $fell(select_program_strobe_n) && program_supply_high;
    endsequence

    sequence s_pulse_hold;
        (!select_program_strobe_n && program_supply_high)[*8];
    endsequence

    property p_pulse_width;
        @(posedge clock) disable iff (!rst_sync_n)
        s_pulse_start |-> s_pulse_hold;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("program pulse too short");

    property p_pulse_needs_vpp;
        @(posedge clock) disable iff (!rst_sync_n)
        $fell(select_program_strobe_n) && (st.op == UVP_OP_PROG) && (st.state == UVP_PULSE) |->
            program_supply_high && main_supply_high && !mem_data_oe_n;
    endproperty
    a_pulse_needs_vpp: assert property (p_pulse_needs_vpp) else $error("pulse without supplies or data");

    property p_no_gate_during_prog;
        @(posedge clock) disable iff (!rst_sync_n)
        program_supply_high |-> output_gate_n;
    endproperty
    a_no_gate_during_prog: assert property (p_no_gate_during_prog) else $error("gate low with supply raised");

    property p_max_pulses;
        @(posedge clock) disable iff (!rst_sync_n)
        st.pulses <= MAXP_C;
    endproperty
    a_max_pulses: assert property (p_max_pulses) else $error("too many pulses");

    property p_fail_at_max;
        @(posedge clock) disable iff (!rst_sync_n)
        (rsp_valid && rsp_fail) |-> (rsp_pulses == MAXP_C);
    endproperty
    a_fail_at_max: assert property (p_fail_at_max) else $error("fail before max pulses");

    property p_ident_lines;
        @(posedge clock) disable iff (!rst_sync_n)
        mem_id_high_volt |-> (mem_addr[ADDR_W-1:1] == '0) && mem_data_oe_n && !program_supply_high;
    endproperty
    a_ident_lines: assert property (p_ident_lines) else $error("ident lines not low");

    property p_data_held;
        @(posedge clock) disable iff (!rst_sync_n)
        !select_program_strobe_n && program_supply_high |-> $stable(mem_data_out) && $stable(mem_addr);
    endproperty
    a_data_held: assert property (p_data_held) else $error("data moved during pulse");

    property p_no_contention;
        @(posedge clock) disable iff (!rst_sync_n)
        !output_gate_n |-> mem_data_oe_n;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("bus contention");
endmodule
`default_nettype wire

// [tb/uvp_dev_model.sv]
`timescale 1ns/10ps
`default_nettype none
module uvp_dev_model #(
    parameter int         SEL_NS      = 200,
    parameter int         GATE_NS     = 50,
    parameter int         SLOW        = 3,
    // Arbitrary identity values
    parameter logic [7:0] MAKER_CODE  = 8'h3C,
    parameter logic [7:0] DEVICE_CODE = 8'h71
) (
    input  wire logic [15:0] addr,
    input  wire logic        id_hv,
    input  wire logic        strobe_n,
    input  wire logic        gate_n,
    input  wire logic        vpp,
    input  wire logic [7:0]  host_data,
    input  wire logic        host_oe_n,
    output logic      [7:0]  bus
);
    logic [7:0]  cells [0:65535];
    logic [7:0]  last   = 8'h00;
    logic        sel_ok;
    logic        gate_ok;
    logic        drive;
    logic [15:0] last_a = 16'h0000;
    int          hits   = 0;

    initial begin
        for (int i = 0; i < 65536; i++) cells[i] = 8'hFF;
    end

    assign #(SEL_NS) sel_ok = !strobe_n;
    assign #(GATE_NS) gate_ok = !gate_n;
    // Both controls low, never at program voltage
    assign drive = !strobe_n && !gate_n && sel_ok && gate_ok && !vpp;

    // ----------------------------------------
    // Pins: floating lines show inverted history
    // ----------------------------------------
    // Identity byte picked by line zero
    always @* begin
        if (drive && !host_oe_n) bus = 8'hXX;
        else if (drive) bus = id_hv ? (addr[0] ? DEVICE_CODE : MAKER_CODE) : cells[addr];
        else if (!host_oe_n) bus = host_data;
        else bus = ~last;
    end

    always @(bus) begin
        if (drive || !host_oe_n) last = bus;
    end

    // ----------------------------------------
    // Programming
    // ----------------------------------------
    // Pulse only clears bits, needs program voltage
    // Cells with top address bit set need SLOW pulses
    always @(posedge strobe_n) begin
        if (vpp && !host_oe_n) begin
            if (addr != last_a) hits = 0;
            last_a = addr;
            hits++;
            if (!addr[15] || hits >= SLOW) cells[addr] = cells[addr] & host_data;
        end
    end
endmodule
`default_nettype wire

// [tb/uvp_prog_ctrl_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module uvp_prog_ctrl_tb;
    import uvp_pkg::*;
    localparam int         PULSE = 20;
    localparam logic [7:0] MAKER = 8'h3C;
    localparam logic [7:0] DEVC  = 8'h71;

    logic        clock;
    logic        reset_n;
    logic        req_valid;
    logic        req_ready;
    logic [1:0]  req_op;
    logic [15:0] req_addr;
    logic [7:0]  req_data;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        rsp_fail;
    logic [4:0]  rsp_pulses;
    logic [15:0] mem_addr;
    logic        mem_id_high_volt;
    logic [7:0]  mem_data_out;
    logic        mem_data_oe_n;
    logic [7:0]  mem_data_in;
    logic        select_program_strobe_n;
    logic        output_gate_n;
    logic        program_supply_high;
    logic        main_supply_high;
    int          num_errors;
    int          samples_checked;
    int          low_cnt;

    uvp_prog_ctrl #(.PULSE_CYC(PULSE)) uvp_prog_ctrl_inst (
        .clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_fail(rsp_fail), .rsp_pulses(rsp_pulses), .mem_addr(mem_addr),
        .mem_id_high_volt(mem_id_high_volt), .mem_data_out(mem_data_out),
        .mem_data_oe_n(mem_data_oe_n), .mem_data_in(mem_data_in),
        .select_program_strobe_n(select_program_strobe_n), .output_gate_n(output_gate_n),
        .program_supply_high(program_supply_high), .main_supply_high(main_supply_high));

    uvp_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVC)) dev (
        .addr(mem_addr), .id_hv(mem_id_high_volt), .strobe_n(select_program_strobe_n),
        .gate_n(output_gate_n), .vpp(program_supply_high), .host_data(mem_data_out),
        .host_oe_n(mem_data_oe_n), .bus(mem_data_in));

    // Paralleled part left deselected, shares every other line except its data bus, which is left open
    uvp_dev_model dev_idle (
        .addr(mem_addr), .id_hv(mem_id_high_volt), .strobe_n(1'b1), .gate_n(output_gate_n),
        .vpp(program_supply_high), .host_data(mem_data_out), .host_oe_n(mem_data_oe_n), .bus());

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ----------------------------------------
    // Request and wait for answer
    // ----------------------------------------
    task automatic run_op(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 1000) begin num_errors++; summarize(); end
        end
        @(posedge clock);
        req_valid <= 1'b1;
        req_op    <= op;
        req_addr  <= a;
        req_data  <= d;
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
            if (n > 30000) begin num_errors++; summarize(); end
        end while (rsp_valid !== 1'b1);
    endtask

    // ----------------------------------------
    // Pin monitors during every operation
    // ----------------------------------------
    always @(posedge clock) begin
        if (!reset_n) begin
            low_cnt <= 0;
        end else begin
            if (program_supply_high) check("main_supply", main_supply_high, 1'b1);
            // Gate never low at program voltage
            if (!output_gate_n) check("vpp_in_read", program_supply_high, 1'b0);
            if (mem_id_high_volt) check("id_addr_hi", mem_addr[15:1], 15'h0000);
            if (!select_program_strobe_n && program_supply_high) begin
                check("prog_oe_n", mem_data_oe_n, 1'b0);
                check("prog_data", mem_data_out, req_data);
                check("prog_addr", mem_addr, req_addr);
                low_cnt <= low_cnt + 1;
            end else begin
                if (low_cnt != 0) check("pulse_w", 16'(low_cnt >= PULSE && low_cnt <= PULSE + 2), 16'h0001);
                low_cnt <= 0;
            end
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check("rst_strobe", select_program_strobe_n, 1'b1);
        check("rst_gate", output_gate_n, 1'b1);
        check("rst_vpp", program_supply_high, 1'b0);
        check("rst_oe_n", mem_data_oe_n, 1'b1);
        check("rst_ready", req_ready, 1'b0);
    endtask

    task automatic t_prog_read();
        run_op(2'h0, 16'h4321, 8'h00);
        check("erased", rsp_data, 8'hFF);
        run_op(2'h1, 16'h1234, 8'hA5);
        check("prog_fail", rsp_fail, 1'b0);
        check("prog_pulses", rsp_pulses, 5'h01);
        check("vcc_off", main_supply_high, 1'b0);
        check("vpp_off", program_supply_high, 1'b0);
        run_op(2'h0, 16'h1234, 8'h00);
        check("readback", rsp_data, 8'hA5);
        check("inhibited", dev_idle.cells[16'h1234], 8'hFF);
    endtask

    task automatic t_slow();
        run_op(2'h1, 16'h8001, 8'h3C);
        check("slow_pulses", rsp_pulses, 5'h03);
        check("slow_fail", rsp_fail, 1'b0);
        check("slow_data", rsp_data, 8'h3C);
    endtask

    task automatic t_fail();
        // Ones over programmed zeros can never verify
        run_op(2'h1, 16'h1234, 8'hFF);
        check("fail_flag", rsp_fail, 1'b1);
        check("fail_pulses", rsp_pulses, 5'h19);
        check("fail_vcc_off", main_supply_high, 1'b0);
        run_op(2'h0, 16'h1234, 8'h00);
        check("no_restore", rsp_data, 8'hA5);
    endtask

    task automatic t_ident();
        run_op(2'h2, 16'hFFFE, 8'h00);
        check("maker_code", rsp_data, MAKER);
        run_op(2'h2, 16'h5A01, 8'h00);
        check("device_code", rsp_data, DEVC);
    endtask

    initial begin
        reset_n         = 1'b0;
        req_valid       = 1'b0;
        req_op          = 2'h0;
        req_addr        = 16'h0000;
        req_data        = 8'h00;
        num_errors      = 0;
        samples_checked = 0;
        repeat (8) @(posedge clock);
        t_reset();
        reset_n <= 1'b1;
        t_prog_read();
        t_slow();
        t_fail();
        t_ident();
        summarize();
    end
endmodule
`default_nettype wire
